// [hdl/interrupt_request_controller.sv]
// interrupt request controller with apb registers and stack sequencer
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// Contract
// - seven sources, two pins, three timers, a comparator, a pwm, one flag each.
// - each source reaches the cpu only through its own writable enable bit.
// - flags are set by hardware only; writing zero to a flag bit clears it.
// - each source's flag edge is selectable as rising, falling or both, except the timer's, which is rising or falling.
// - a global enable, set and cleared by two instructions, gates all lines.
// - a flag is still set by its event while its enable bit is zero.
// - taking an interrupt stores the pc at the stack pointer, which grows by 2.
// - taking an interrupt clears the global enable and jumps to 0x010.
// - return reloads the pc from the stack, drops it by 2, sets the enable.
// - the flag register is readable so the handler finds its sources.
// - push and pop save and restore accumulator and flags via the stack.
// - the timer source is a selectable counter bit 15..8 with one edge bit.
module interrupt_request_controller (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port_a_pin_zero,
    input  wire logic        port_b_pin_zero,
    input  wire logic [7:0]  t16_count_hi,
    input  wire logic        comparator_out,
    input  wire logic        second_timer_out,
    input  wire logic        third_timer_out,
    input  wire logic        pwm_generator_zero_out,
    input  wire logic        insn_boundary,
    input  wire logic [15:0] pc_in,
    input  wire logic        reti_req,
    input  wire logic        engint_req,
    input  wire logic        disgint_req,
    input  wire logic        pushaf_req,
    input  wire logic        popaf_req,
    input  wire logic [15:0] acc_flags_in,
    input  wire logic [15:0] mem_rdata,
    output logic             irq,
    output logic             busy,
    output logic             mem_we,
    output logic             mem_re,
    output logic      [7:0]  mem_addr,
    output logic      [15:0] mem_wdata,
    output logic             pc_load,
    output logic      [15:0] pc_value,
    output logic             af_load,
    output logic      [15:0] af_value
);

    localparam int N       = irc_pkg::NUM_SRC;
    localparam int T16_POL = irc_pkg::EDGE_W * irc_pkg::SRC_T16;

    typedef struct packed {
        logic [1:0]              pin_s1;
        logic [1:0]              pin_s2;
        logic [N-1:0]            flag;
        logic [N-1:0]            en;
        logic [2*N-1:0]          edge_sel;
        logic [2:0]              t16_sel;
        logic [7:0]              sp;
        logic                    ge;
        irc_pkg::ctl_state_e     st;
        logic                    busy;
        logic                    irq;
        logic                    mem_we;
        logic                    mem_re;
        logic [7:0]              mem_addr;
        logic [15:0]             mem_wdata;
        logic                    pc_load;
        logic [15:0]             pc_val;
        logic                    af_load;
        logic [15:0]             af_val;
        logic [31:0]             prdata;
        logic                    pready;
        logic                    pslverr;
    } ctl_s;

    ctl_s r;
    ctl_s n;

    logic [N-1:0] src_lvl;
    logic [N-1:0] rise_en;
    logic [N-1:0] fall_en;
    logic [N-1:0] evt;
    logic         t16_bit;
    logic         wr_acc;
    logic         wr_flag;
    logic         pending;
    logic         take_now;
    logic         reti_ok;
    logic         push_ok;
    logic         pop_ok;

    // timer source is one selectable bit of the upper counter byte
    assign t16_bit = t16_count_hi[r.t16_sel];

    // source vector, pins through their synchronisers
    assign src_lvl = {pwm_generator_zero_out, third_timer_out,
                      second_timer_out, comparator_out, t16_bit,
                      r.pin_s2[1], r.pin_s2[0]};

    // edge enables per source; the timer uses one polarity bit
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_edge
            if (i == irc_pkg::SRC_T16) begin : g_t16
                assign rise_en[i] = ~r.edge_sel[T16_POL];
                assign fall_en[i] = r.edge_sel[T16_POL];
            end else begin : g_gen
                logic [1:0] code;
                // direct select so the enables follow register writes
                assign code =
                    r.edge_sel[irc_pkg::EDGE_W*i +: irc_pkg::EDGE_W];
                assign rise_en[i] = code != irc_pkg::EDGE_FALL;
                assign fall_en[i] = code != irc_pkg::EDGE_RISE;
            end
        end
    endgenerate

    src_edge_detect #(
        .WIDTH (N)
    ) u_edge (
        .clk       (clk),
        .rst       (rst),
        .level     (src_lvl),
        .rise_en   (rise_en),
        .fall_en   (fall_en),
        .event_hit (evt)
    );

    // bus write strobe and sequencer start conditions
    assign wr_acc   = psel & penable & pwrite & r.pready & ~r.pslverr;
    assign wr_flag  = wr_acc && (paddr == irc_pkg::OFF_FLAG);
    assign pending  = |(r.flag & r.en);
    assign take_now = (r.st == irc_pkg::ST_IDLE) && insn_boundary &&
                      r.ge && pending;
    assign reti_ok  = (r.st == irc_pkg::ST_IDLE) && reti_req && !take_now;
    assign push_ok  = (r.st == irc_pkg::ST_IDLE) && pushaf_req &&
                      !take_now && !reti_req;
    assign pop_ok   = (r.st == irc_pkg::ST_IDLE) && popaf_req &&
                      !take_now && !reti_req && !pushaf_req;

    // next state of the whole controller
    always_comb begin
        n = r;
        n.pin_s1  = {port_b_pin_zero, port_a_pin_zero};
        n.pin_s2  = r.pin_s1;
        n.mem_we  = 1'b0;
        n.mem_re  = 1'b0;
        n.pc_load = 1'b0;
        n.af_load = 1'b0;
        n.pready  = psel & ~penable;
        n.pslverr = 1'b0;

        // read data and decode captured in the setup cycle
        if (psel && !penable) begin
            n.prdata = 32'h0000_0000;
            case (paddr)
                irc_pkg::OFF_FLAG:   n.prdata = 32'(r.flag);
                irc_pkg::OFF_ENABLE: n.prdata = 32'(r.en);
                irc_pkg::OFF_EDGE:   n.prdata = 32'(r.edge_sel);
                irc_pkg::OFF_T16SEL: n.prdata = 32'(r.t16_sel);
                irc_pkg::OFF_SP:     n.prdata = 32'(r.sp);
                irc_pkg::OFF_STATUS: begin
                    n.prdata[irc_pkg::STAT_GE]   = r.ge;
                    n.prdata[irc_pkg::STAT_BUSY] = r.busy;
                end
                default:             n.pslverr = 1'b1;
            endcase
        end

        // events set flags regardless of enable, set beats a clear
        n.flag = r.flag | evt;
        if (wr_flag) begin
            n.flag = (r.flag & pwdata[N-1:0]) | evt;
        end

        // configuration writes
        if (wr_acc) begin
            case (paddr)
                irc_pkg::OFF_ENABLE: n.en = pwdata[N-1:0];
                irc_pkg::OFF_EDGE:   n.edge_sel = pwdata[2*N-1:0];
                irc_pkg::OFF_T16SEL: n.t16_sel = pwdata[2:0];
                irc_pkg::OFF_SP:     n.sp = pwdata[7:0];
                default:             n.en = r.en;
            endcase
        end

        // global enable instructions
        if (engint_req) begin
            n.ge = 1'b1;
        end else if (disgint_req) begin
            n.ge = 1'b0;
        end

        // stack sequencer
        case (r.st)
            irc_pkg::ST_IDLE: begin
                if (take_now) begin
                    n.mem_we    = 1'b1;
                    n.mem_addr  = r.sp;
                    n.mem_wdata = pc_in;
                    n.sp        = r.sp + irc_pkg::SP_STEP;
                    n.ge        = 1'b0;
                    n.pc_load   = 1'b1;
                    n.pc_val    = irc_pkg::VECTOR_ADDR;
                end else if (reti_ok) begin
                    n.mem_re   = 1'b1;
                    n.mem_addr = r.sp - irc_pkg::SP_STEP;
                    n.sp       = r.sp - irc_pkg::SP_STEP;
                    n.st       = irc_pkg::ST_RET_RD;
                end else if (push_ok) begin
                    n.mem_we    = 1'b1;
                    n.mem_addr  = r.sp;
                    n.mem_wdata = acc_flags_in;
                    n.sp        = r.sp + irc_pkg::SP_STEP;
                end else if (pop_ok) begin
                    n.mem_re   = 1'b1;
                    n.mem_addr = r.sp - irc_pkg::SP_STEP;
                    n.sp       = r.sp - irc_pkg::SP_STEP;
                    n.st       = irc_pkg::ST_POP_RD;
                end
            end
            irc_pkg::ST_RET_RD: n.st = irc_pkg::ST_RET_WT;
            irc_pkg::ST_RET_WT: begin
                n.pc_load = 1'b1;
                n.pc_val  = mem_rdata;
                n.ge      = 1'b1;
                n.st      = irc_pkg::ST_IDLE;
            end
            irc_pkg::ST_POP_RD: n.st = irc_pkg::ST_POP_WT;
            irc_pkg::ST_POP_WT: begin
                n.af_load = 1'b1;
                n.af_val  = mem_rdata;
                n.st      = irc_pkg::ST_IDLE;
            end
            default: n.st = irc_pkg::ST_IDLE;
        endcase

        // level interrupt and busy follow the next state
        n.busy = n.st != irc_pkg::ST_IDLE;
        n.irq  = n.ge && |(n.flag & n.en);
    end

    // register the whole state
    always_ff @(posedge clk) begin
        if (rst) begin
            r          <= '0;
            r.flag     <= irc_pkg::FLAG_RST;
            r.en       <= irc_pkg::ENABLE_RST;
            r.edge_sel <= irc_pkg::EDGE_RST;
            r.t16_sel  <= irc_pkg::T16SEL_RST;
            r.sp       <= irc_pkg::SP_RST;
            r.st       <= irc_pkg::ST_IDLE;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state flops
    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;
    assign irq       = r.irq;
    assign busy      = r.busy;
    assign mem_we    = r.mem_we;
    assign mem_re    = r.mem_re;
    assign mem_addr  = r.mem_addr;
    assign mem_wdata = r.mem_wdata;
    assign pc_load   = r.pc_load;
    assign pc_value  = r.pc_val;
    assign af_load   = r.af_load;
    assign af_value  = r.af_val;

    // event sets its flag on the next edge, enabled or not
    property p_flag_set;
        @(posedge clk) disable iff (rst)
        |evt |=> ((r.flag & $past(evt)) == $past(evt));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("event did not set its flag");

    // no flag rises without an event
    property p_no_sw_set;
        @(posedge clk) disable iff (rst)
        !rst |=> ((r.flag & ~$past(r.flag) & ~$past(evt)) == '0);
    endproperty
    a_no_sw_set: assert property (p_no_sw_set)
        else $error("flag set without a source event");

    // zero written to a flag bit clears it unless an event hits
    property p_sw_clear;
        @(posedge clk) disable iff (rst)
        wr_flag |=> ((r.flag & ~$past(pwdata[N-1:0]) &
                      ~$past(evt)) == '0);
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("flag write did not clear");

    // interrupt line gated by enables and global enable
    property p_irq_gate;
        @(posedge clk) disable iff (rst)
        irq == (r.ge && |(r.flag & r.en));
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq does not match gated flags");

    // take pushes pc and steps the stack pointer
    property p_take_push;
        @(posedge clk) disable iff (rst)
        take_now |=> mem_we && mem_addr == $past(r.sp) &&
                     mem_wdata == $past(pc_in) &&
                     r.sp == $past(r.sp) + irc_pkg::SP_STEP;
    endproperty
    a_take_push: assert property (p_take_push)
        else $error("interrupt entry stack push wrong");

    // take vectors and clears the global enable
    property p_take_vec;
        @(posedge clk) disable iff (rst)
        take_now |=> pc_load && pc_value == irc_pkg::VECTOR_ADDR &&
                     !r.ge ##1 !pc_load;
    endproperty
    a_take_vec: assert property (p_take_vec)
        else $error("interrupt entry vector wrong");

    // entry only with enable and a pending line
    property p_take_cond;
        @(posedge clk) disable iff (rst)
        (mem_we && pc_load) |->
            $past(r.ge && pending && insn_boundary);
    endproperty
    a_take_cond: assert property (p_take_cond)
        else $error("interrupt taken without cause");

    // return sequence: read below the pointer, then reload pc
    sequence s_ret_start;
        reti_ok;
    endsequence
    sequence s_ret_done;
        mem_re && mem_addr == r.sp ##2 pc_load && r.ge &&
        pc_value == $past(mem_rdata);
    endsequence
    property p_reti;
        @(posedge clk) disable iff (rst)
        s_ret_start |=> s_ret_done;
    endproperty
    a_reti: assert property (p_reti)
        else $error("return sequence wrong");

    // pop sequence restores accumulator and flags
    sequence s_pop_start;
        pop_ok;
    endsequence
    sequence s_pop_done;
        mem_re ##1 busy ##1 af_load && af_value == $past(mem_rdata);
    endsequence
    property p_pop;
        @(posedge clk) disable iff (rst)
        s_pop_start |=> s_pop_done;
    endproperty
    a_pop: assert property (p_pop)
        else $error("pop sequence wrong");

    // timer bit rising with rising polarity sets its flag
    property p_t16_edge;
        @(posedge clk) disable iff (rst)
        ($rose(t16_bit) && !$past(r.edge_sel[T16_POL]) &&
         $stable(r.t16_sel) && !r.edge_sel[T16_POL])
            |=> r.flag[irc_pkg::SRC_T16];
    endproperty
    a_t16_edge: assert property (p_t16_edge)
        else $error("timer bit edge lost");

endmodule

// [hdl/irc_pkg.sv]
// shared constants and types of the interrupt request controller
package irc_pkg;

    // source count and positions in the flag, enable and edge fields
    localparam int NUM_SRC   = 7;
    localparam int SRC_PA0   = 0;
    localparam int SRC_PB0   = 1;
    localparam int SRC_T16   = 2;
    localparam int SRC_CMP   = 3;
    localparam int SRC_TM2   = 4;
    localparam int SRC_TM3   = 5;
    localparam int SRC_PWM   = 6;
    localparam int EDGE_W    = 2;

    // apb register byte offsets
    localparam logic [7:0] OFF_FLAG   = 8'h00;
    localparam logic [7:0] OFF_ENABLE = 8'h04;
    localparam logic [7:0] OFF_EDGE   = 8'h08;
    localparam logic [7:0] OFF_T16SEL = 8'h0c;
    localparam logic [7:0] OFF_SP     = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;

    // status register bit positions
    localparam int STAT_GE   = 0;
    localparam int STAT_BUSY = 1;

    // per-source edge select codes
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    // reset values
    localparam logic [6:0]  FLAG_RST   = 7'h00;
    localparam logic [6:0]  ENABLE_RST = 7'h00;
    localparam logic [13:0] EDGE_RST   = 14'h0000;
    localparam logic [2:0]  T16SEL_RST = 3'h0;
    localparam logic [7:0]  SP_RST     = 8'h00;

    // vector and stack step
    localparam logic [15:0] VECTOR_ADDR = 16'h0010;
    localparam logic [7:0]  SP_STEP     = 8'h02;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RET_RD,
        ST_RET_WT,
        ST_POP_RD,
        ST_POP_WT
    } ctl_state_e;

endpackage

// [hdl/src_edge_detect.sv]
// per-source edge detector with rise and fall enables
`timescale 1ns/1ps

module src_edge_detect #(
    parameter int WIDTH = 7
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] level,
    input  wire logic [WIDTH-1:0] rise_en,
    input  wire logic [WIDTH-1:0] fall_en,
    output logic      [WIDTH-1:0] event_hit
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } det_s;

    det_s r;
    det_s n;

    // remember the level of the last clock
    always_comb begin
        n      = r;
        n.prev = level;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // one pulse per qualified change
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign event_hit[i] =
                (rise_en[i] & level[i] & ~r.prev[i]) |
                (fall_en[i] & ~level[i] & r.prev[i]);
        end
    endgenerate

endmodule

// [sim/stack_memory_model.sv]
// data memory model on the far side of the stack port
`timescale 1ns/1ps

module stack_memory_model (
    input  wire logic        clk,
    input  wire logic        mem_we,
    input  wire logic        mem_re,
    input  wire logic [7:0]  mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata
);
    logic [15:0] mem [256];
    logic [15:0] rdata_r;

    // shared stack words, read data valid one cycle after a read pulse
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_re) begin
            rdata_r <= mem[mem_addr];
        end else begin
            rdata_r <= ~rdata_r; // released bus keeps changing
        end
    end

    assign mem_rdata = rdata_r;
endmodule

// [sim/tb_interrupt_request_controller.sv]
// self-checking bench for the interrupt request controller
`timescale 1ns/1ps

module tb_interrupt_request_controller;
    typedef struct {
        logic [7:0]  a;
        logic        w;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } row_s;

    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, t16_hi, mem_addr;
    logic [31:0] pwdata, prdata, rd;
    logic        pa0, pb0, cmp, tm2, tm3, pwm, insn_b, reti, eng, dis;
    logic        push, pop, irq, busy, mem_we, mem_re, pc_load, af_load;
    logic [15:0] pc_in, acc_in, mem_rdata, mem_wdata, pc_value, af_value;
    logic        err;
    int          failures, n_compared;
    row_s        rows[11];

    interrupt_request_controller interrupt_request_controller_inst (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_a_pin_zero(pa0), .port_b_pin_zero(pb0),
        .t16_count_hi(t16_hi), .comparator_out(cmp),
        .second_timer_out(tm2), .third_timer_out(tm3),
        .pwm_generator_zero_out(pwm), .insn_boundary(insn_b),
        .pc_in(pc_in), .reti_req(reti), .engint_req(eng),
        .disgint_req(dis), .pushaf_req(push), .popaf_req(pop),
        .acc_flags_in(acc_in), .mem_rdata(mem_rdata), .irq(irq),
        .busy(busy), .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .pc_load(pc_load),
        .pc_value(pc_value), .af_load(af_load), .af_value(af_value)
    );

    stack_memory_model stack_memory_model_inst (
        .clk(clk), .mem_we(mem_we), .mem_re(mem_re),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata)
    );

    // 20 mhz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk("pready", 32'h1, 32'h0);
    endtask

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(n, e, rd);
    endtask

    task automatic set_src(input int s, input logic v);
        @(posedge clk);
        case (s)
            0: pa0 <= v;
            1: pb0 <= v;
            2: t16_hi[0] <= v;
            3: cmp <= v;
            4: tm2 <= v;
            5: tm3 <= v;
            default: pwm <= v;
        endcase
        repeat (6) @(posedge clk);
    endtask

    // one-cycle request pulse, outputs sampled after the taking edge
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: insn_b <= 1'b1;
            1: reti <= 1'b1;
            2: eng <= 1'b1;
            3: dis <= 1'b1;
            4: push <= 1'b1;
            default: pop <= 1'b1;
        endcase
        @(posedge clk);
        {insn_b, reti, eng, dis, push, pop} <= 6'h00;
        #1;
    endtask

    task automatic wait_load(input logic af);
        int n;
        n = 0;
        while ((af ? af_load : pc_load) !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("load pulse", 32'h1, 32'(af ? af_load : pc_load));
    endtask

    initial begin
        #500000;
        failures++;
        give_verdict();
    end

    initial begin
        {psel, penable, pwrite, pa0, pb0, cmp, tm2, tm3, pwm} = '0;
        {insn_b, reti, eng, dis, push, pop} = '0;
        {paddr, t16_hi, pwdata, pc_in, acc_in} = '0;
        failures = 0;
        n_compared = 0;
        rst = 1'b1;
        rows = '{
            '{irc_pkg::OFF_SP, 0, 0, 0, 0},
            '{irc_pkg::OFF_FLAG, 0, 0, 0, 0},
            '{irc_pkg::OFF_STATUS, 0, 0, 0, 0},
            '{irc_pkg::OFF_ENABLE, 1, '1, 0, 0},
            '{irc_pkg::OFF_ENABLE, 0, 0, 32'h0000007f, 0},
            '{irc_pkg::OFF_EDGE, 1, '1, 0, 0},
            '{irc_pkg::OFF_EDGE, 0, 0, 32'h00003fff, 0},
            '{irc_pkg::OFF_T16SEL, 1, '1, 0, 0},
            '{irc_pkg::OFF_T16SEL, 0, 0, 32'h00000007, 0},
            '{8'h18, 1, '1, 0, 1},
            '{8'h18, 0, 0, 0, 1}};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // register table rows
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w) chk("reg read", rows[i].e, rd);
            chk("pslverr", 32'(rows[i].err), 32'(err));
        end
        apb(irc_pkg::OFF_EDGE, 1, 0);
        apb(irc_pkg::OFF_T16SEL, 1, 0);
        apb(irc_pkg::OFF_ENABLE, 1, 0);
        // every source on both edges, timer on rising only
        for (int s = 0; s < 7; s++) begin
            set_src(s, 1'b1);
            rdchk("flag rise", irc_pkg::OFF_FLAG, 32'(1 << s));
            apb(irc_pkg::OFF_FLAG, 1, 0);
            set_src(s, 1'b0);
            rdchk("flag fall", irc_pkg::OFF_FLAG,
                  (s == 2) ? 0 : 32'(1 << s));
            apb(irc_pkg::OFF_FLAG, 1, 0);
        end
        // every edge code on the comparator
        for (int c = 0; c < 4; c++) begin
            apb(irc_pkg::OFF_EDGE, 1, 32'(c << 6));
            set_src(3, 1'b1);
            rdchk("cmp rise", irc_pkg::OFF_FLAG, (c == 2) ? 0 : 8);
            apb(irc_pkg::OFF_FLAG, 1, 0);
            set_src(3, 1'b0);
            rdchk("cmp fall", irc_pkg::OFF_FLAG, (c == 1) ? 0 : 8);
            apb(irc_pkg::OFF_FLAG, 1, 0);
        end
        // timer bit select 11, falling edge
        apb(irc_pkg::OFF_T16SEL, 1, 3);
        apb(irc_pkg::OFF_EDGE, 1, 32'h10);
        @(posedge clk) t16_hi <= 8'h09;
        repeat (4) @(posedge clk);
        @(posedge clk) t16_hi <= 8'h08;
        rdchk("t16 unselected", irc_pkg::OFF_FLAG, 0);
        @(posedge clk) t16_hi <= 8'h00;
        repeat (4) @(posedge clk);
        rdchk("t16 selected", irc_pkg::OFF_FLAG, 4);
        apb(irc_pkg::OFF_FLAG, 1, 0);
        // gating, entry, selective clear
        apb(irc_pkg::OFF_SP, 1, 32'h20);
        set_src(3, 1'b1);
        set_src(4, 1'b1);
        chk("irq no enable", 0, 32'(irq));
        apb(irc_pkg::OFF_ENABLE, 1, 8);
        chk("irq no global", 0, 32'(irq));
        pulse(2);
        repeat (3) @(posedge clk);
        chk("irq on", 1, 32'(irq));
        pc_in <= 16'h1234;
        pulse(0);
        chk("entry we", 1, 32'(mem_we));
        chk("entry addr", 32'h20, 32'(mem_addr));
        chk("entry data", 32'h1234, 32'(mem_wdata));
        chk("entry load", 1, 32'(pc_load));
        chk("vector", 32'(irc_pkg::VECTOR_ADDR), 32'(pc_value));
        rdchk("sp up", irc_pkg::OFF_SP, 32'h22);
        rdchk("ge off", irc_pkg::OFF_STATUS, 0);
        chk("irq off", 0, 32'(irq));
        apb(irc_pkg::OFF_FLAG, 1, 32'hfffffff7);
        rdchk("one cleared", irc_pkg::OFF_FLAG, 32'h10);
        // return
        pulse(1);
        chk("return re", 1, 32'(mem_re));
        chk("return addr", 32'h20, 32'(mem_addr));
        chk("return busy", 1, 32'(busy));
        wait_load(1'b0);
        chk("return pc", 32'h1234, 32'(pc_value));
        rdchk("sp down", irc_pkg::OFF_SP, 32'h20);
        rdchk("ge on", irc_pkg::OFF_STATUS, 1);
        // push then pop
        acc_in <= 16'hbeef;
        pulse(4);
        chk("push data", 32'hbeef, 32'(mem_wdata));
        chk("push addr", 32'h20, 32'(mem_addr));
        acc_in <= 16'h0000;
        pulse(5);
        chk("pop re", 1, 32'(mem_re));
        chk("pop busy", 1, 32'(busy));
        wait_load(1'b1);
        chk("pop data", 32'hbeef, 32'(af_value));
        rdchk("sp after pop", irc_pkg::OFF_SP, 32'h20);
        pulse(3);
        rdchk("ge disabled", irc_pkg::OFF_STATUS, 0);
        // mid-run reset clears enables, pointer and outputs
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("rst irq", 0, 32'(irq));
        chk("rst busy", 0, 32'(busy));
        rdchk("rst enable", irc_pkg::OFF_ENABLE, 0);
        rdchk("rst sp", irc_pkg::OFF_SP, 0);
        give_verdict();
    end
endmodule
